// ### can_regs_defs.vh
`ifndef CAN_REGS_DEFS_VH
`define CAN_REGS_DEFS_VH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define A_MODULE_CONTROL  12'h000
`define A_MODULE_STATE    12'h004
`define A_LINK_ERR_STATE  12'h008
`define A_TX_ERR_COUNTER  12'h00C
`define A_EVENT_IN        12'h010
`define A_RX_ERR_COUNTER  12'h014
`define A_WIN_BASE        12'h040
// window word index inside the access area
`define W_CONTROL         4'h0
`define W_SIDH            4'h1
`define W_SIDL            4'h2
`define W_EIDH            4'h3
`define W_EIDL            4'h4
`define W_DATA0           4'h5
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define CTL_RESET         8'h80
`define CTL_WMASK         8'hFE
`define SIDL_WMASK        8'hEB
`define TXCON_WMASK       8'h0B
`define MODE_CONFIG       3'h4
`define MODE_LISTEN       3'h3
`define MODE_LOOP         3'h2
`define MODE_DISABLE      3'h1
`define MODE_NORMAL       3'h0
`define WARN_LIMIT        8'h5F
`define PASSIVE_LIMIT     8'h7F
`define RECESSIVE_RUN     4'hB
`endif

// ### can_ctrl_status_tx_buffers.v
`timescale 1ns/1ns
`default_nettype none
`include "can_regs_defs.vh"
module can_ctrl_status_tx_buffers (
  input  wire        I_CLK,
  input  wire        I_RESET_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // protocol engine side (same clock)
  input  wire        i_mode_ack,
  input  wire        i_tx_done,
  input  wire        i_tx_lost_arb,
  input  wire        i_tx_bus_err,
  input  wire        i_tx_abort_ack,
  input  wire        i_tx_err_inc8,
  input  wire        i_tx_err_dec,
  input  wire        i_bit_tick,
  input  wire        i_rx_bit,
  input  wire        i_rx0_ovf,
  input  wire        i_rx1_ovf,
  input  wire [6:0]  i_irq_pend,
  output reg  [2:0]  o_mode_state,
  output reg  [1:0]  o_tx_sel,
  output reg         o_tx_start,
  output reg         o_tx_abort,
  output reg         o_tx_ext,
  output reg  [28:0] o_tx_id,
  output reg         o_bus_off
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  reg  [7:0]  ctl_r;
  reg  [2:0]  mode_r;
  reg  [7:0]  tec_r;
  reg  [7:0]  rec_r;
  reg         ovf0_r;
  reg         ovf1_r;
  reg         busoff_r;
  reg  [3:0]  run_r;
  reg  [7:0]  txcon_r [0:2];
  reg  [7:0]  sidh_r  [0:2];
  reg  [7:0]  sidl_r  [0:2];
  reg  [7:0]  eidh_r  [0:2];
  reg  [7:0]  eidl_r  [0:2];
  reg  [7:0]  data_r  [0:23];
  reg         busy_r;
  reg  [1:0]  cur_r;
  integer     k;

  // a write lands only at the access edge, when ready is already high
  wire        wr      = PSEL & PENABLE & PWRITE;
  wire [2:0]  win     = ctl_r[3:1];
  // the window decode follows the interrupt code so a copy lands right
  wire        win_tx  = (win == 3'h4) | (win == 3'h3) | (win == 3'h2);
  wire [1:0]  win_buf = (win == 3'h4) ? 2'd0 : ((win == 3'h3) ? 2'd1 : 2'd2);
  wire        in_win  = (PADDR[11:6] == 6'h01);
  // window area: word 0 control, words 1 to 4 identifier, 5 to 12 payload
  wire [3:0]  widx    = PADDR[5:2];
  // payload of all three buffers shares one array, eight bytes per buffer
  wire [4:0]  didx    = {win_buf, 3'b000} + {1'b0, widx[3:0]} - 5'd5;
  wire        tx_win  = in_win & win_tx;
  // a dropped request: an idle buffer is aborted at once, the buffer on the
  // wire has to wait until the engine lets go of it
  wire        ctl_wr  = wr & tx_win & (widx == `W_CONTROL);
  wire        drop_rq = ctl_wr & txcon_r[win_buf][3] & ~PWDATA[3];
  wire        on_wire = busy_r & (cur_r == win_buf);
  // limits are strict: a flag needs its count above the limit
  wire        warn_tx = tec_r > `WARN_LIMIT;
  wire        warn_rx = rec_r > `WARN_LIMIT;
  wire        pas_tx  = tec_r > `PASSIVE_LIMIT;
  wire        pas_rx  = rec_r > `PASSIVE_LIMIT;
  // link error state, msb first: rx0 overflow, rx1 overflow, bus-off,
  // tx passive, rx passive, tx warning, rx warning, any warning
  wire [7:0]  link_error_state = {ovf0_r, ovf1_r, busoff_r, pas_tx, pas_rx, warn_tx, warn_rx,
                         warn_tx | warn_rx};
  // wake-up outranks receive, receive outranks transmit, errors come last
  wire [2:0]  icode   = i_irq_pend[6] ? 3'h7 : i_irq_pend[5] ? 3'h6 :
                        i_irq_pend[4] ? 3'h5 : i_irq_pend[3] ? 3'h4 :
                        i_irq_pend[2] ? 3'h3 : i_irq_pend[1] ? 3'h2 :
                        i_irq_pend[0] ? 3'h1 : 3'h0;
  // the request bits feed both the launch pick and the abort-all drain
  wire        req0    = txcon_r[0][3];
  wire        req1    = txcon_r[1][3];
  wire        req2    = txcon_r[2][3];
  wire        any_req = req0 | req1 | req2;

  // ---------------------------------------------------------------
  // highest-priority pending buffer; lower index wins a tie
  // ---------------------------------------------------------------
  reg  [1:0] pick;
  reg  [2:0] best;
  always @* begin
    pick = 2'd0;
    best = 3'd0;
    if (req2) begin
      pick = 2'd2;
      best = {1'b1, txcon_r[2][1:0]};
    end
    if (req1 && ({1'b1, txcon_r[1][1:0]} >= best)) begin
      pick = 2'd1;
      best = {1'b1, txcon_r[1][1:0]};
    end
    if (req0 && ({1'b1, txcon_r[0][1:0]} >= best)) begin
      pick = 2'd0;
      best = {1'b1, txcon_r[0][1:0]};
    end
  end

  // ---------------------------------------------------------------
  // control, mode and error state
  // ---------------------------------------------------------------
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      // wakes in configuration so nothing is sent before setup
      ctl_r    <= `CTL_RESET;
      mode_r   <= `MODE_CONFIG;
      tec_r    <= 8'h00;
      rec_r    <= 8'h00;
      ovf0_r   <= 1'b0;
      ovf1_r   <= 1'b0;
      busoff_r <= 1'b0;
      run_r    <= 4'h0;
    end else begin
      if (wr && PADDR == `A_MODULE_CONTROL)
        ctl_r <= PWDATA[7:0] & `CTL_WMASK;
      else if (ctl_r[4] && !any_req && !busy_r)
        ctl_r[4] <= 1'b0;
      // the engine acks a mode change at a safe point, so status lags request
      if (i_mode_ack)
        mode_r <= ctl_r[7] ? `MODE_CONFIG : ctl_r[7:5];
      // overflow flag: set beats a write-zero clear in the same cycle
      if (i_rx0_ovf)
        ovf0_r <= 1'b1;
      else if (wr && PADDR == `A_LINK_ERR_STATE && !PWDATA[7])
        ovf0_r <= 1'b0;
      if (i_rx1_ovf)
        ovf1_r <= 1'b1;
      else if (wr && PADDR == `A_LINK_ERR_STATE && !PWDATA[6])
        ovf1_r <= 1'b0;
      // recessive run length; it saturates so a long idle bus clears only once
      if (i_bit_tick)
        run_r <= i_rx_bit ? ((run_r == `RECESSIVE_RUN) ? run_r : run_r + 4'h1) : 4'h0;
      // the idle run wins over a software write and an error count in one bit
      if (i_bit_tick && i_rx_bit && run_r == `RECESSIVE_RUN - 4'h1) begin
        tec_r    <= 8'h00;
        busoff_r <= 1'b0;
      end else if (wr && PADDR == `A_TX_ERR_COUNTER) begin
        tec_r <= PWDATA[7:0];
      end else if (i_tx_err_inc8) begin
        // saturate rather than wrap: a wrap would hide the bus-off condition
        if (tec_r > 8'hF7) begin
          tec_r    <= 8'hFF;
          busoff_r <= 1'b1;
        end else begin
          tec_r <= tec_r + 8'h08;
        end
      end else if (i_tx_err_dec && tec_r != 8'h00) begin
        // a decrement at zero stays at zero
        tec_r <= tec_r - 8'h01;
      end
      if (wr && PADDR == `A_RX_ERR_COUNTER)
        rec_r <= PWDATA[7:0];
    end
  end

  // ---------------------------------------------------------------
  // transmit buffers and launch sequencing
  // ---------------------------------------------------------------
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      for (k = 0; k < 3; k = k + 1) begin
        txcon_r[k] <= 8'h00;
        sidh_r[k]  <= 8'h00;
        sidl_r[k]  <= 8'h00;
        eidh_r[k]  <= 8'h00;
        eidl_r[k]  <= 8'h00;
      end
      for (k = 0; k < 24; k = k + 1)
        data_r[k] <= 8'h00;
      busy_r     <= 1'b0;
      cur_r      <= 2'd0;
      o_tx_start <= 1'b0;
      o_tx_abort <= 1'b0;
      o_tx_sel   <= 2'd0;
      o_tx_ext   <= 1'b0;
      o_tx_id    <= 29'h0;
    end else begin
      o_tx_start <= 1'b0;
      o_tx_abort <= 1'b0;
      if (wr && tx_win) begin
        case (widx)
          `W_CONTROL: begin
            // clearing a live request turns into an abort
            if (drop_rq && on_wire)
              o_tx_abort <= 1'b1;
            // setting the request starts a fresh attempt, so old outcome flags go
            if (PWDATA[3])
              txcon_r[win_buf] <= PWDATA[7:0] & `TXCON_WMASK;
            else
              txcon_r[win_buf] <= {1'b0, txcon_r[win_buf][6] | (drop_rq & ~on_wire),
                                   txcon_r[win_buf][5:4], 4'h0} |
                                  (PWDATA[7:0] & `TXCON_WMASK);
          end
          `W_SIDH: sidh_r[win_buf] <= PWDATA[7:0];
          `W_SIDL: sidl_r[win_buf] <= PWDATA[7:0] & `SIDL_WMASK;
          `W_EIDH: eidh_r[win_buf] <= PWDATA[7:0];
          `W_EIDL: eidl_r[win_buf] <= PWDATA[7:0];
          default: begin
            if (widx >= `W_DATA0 && widx < `W_DATA0 + 4'h8)
              data_r[didx] <= PWDATA[7:0];
          end
        endcase
      end
      // abort-all: idle requests drop at once, the active one waits for the engine
      if (ctl_r[4]) begin
        for (k = 0; k < 3; k = k + 1)
          if (txcon_r[k][3] && !(busy_r && cur_r == k[1:0])) begin
            txcon_r[k][3] <= 1'b0;
            txcon_r[k][6] <= 1'b1;
          end
        if (busy_r)
          o_tx_abort <= 1'b1;
      end
      // listen-only and disable keep off the bus; bus-off waits for the idle run
      if (!busy_r && any_req && !ctl_r[4] && mode_r != `MODE_CONFIG &&
          mode_r != `MODE_DISABLE && mode_r != `MODE_LISTEN && !busoff_r) begin
        busy_r     <= 1'b1;
        cur_r      <= pick;
        o_tx_sel   <= pick;
        o_tx_start <= 1'b1;
        o_tx_ext   <= sidl_r[pick][3];
        // identifier and format freeze at launch, so later writes cannot tear a frame
        o_tx_id    <= {sidh_r[pick], sidl_r[pick][7:5], sidl_r[pick][1:0],
                       eidh_r[pick], eidl_r[pick]};
        // outcome flags survive retries; only software setting the request clears them
      end else if (busy_r) begin
        // lost arbitration and bus errors keep the request, so the buffer retries
        if (i_tx_done) begin
          busy_r <= 1'b0;
          txcon_r[cur_r][3] <= 1'b0;
        end else if (i_tx_abort_ack) begin
          busy_r <= 1'b0;
          txcon_r[cur_r][3] <= 1'b0;
          txcon_r[cur_r][6] <= 1'b1;
        end else if (i_tx_lost_arb) begin
          busy_r <= 1'b0;
          txcon_r[cur_r][5] <= 1'b1;
        end else if (i_tx_bus_err) begin
          busy_r <= 1'b0;
          txcon_r[cur_r][4] <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // APB read side; zero wait states, unmapped reads zero with error
  // ---------------------------------------------------------------
  reg [7:0] rd_v;
  reg       hit;
  always @* begin
    rd_v = 8'h00;
    hit  = 1'b1;
    // window reads of a receive buffer give zero; that storage lives elsewhere
    if (in_win) begin
      if (win_tx) begin
        case (widx)
          `W_CONTROL: rd_v = txcon_r[win_buf] & 8'h7B;
          `W_SIDH:    rd_v = sidh_r[win_buf];
          `W_SIDL:    rd_v = sidl_r[win_buf];
          `W_EIDH:    rd_v = eidh_r[win_buf];
          `W_EIDL:    rd_v = eidl_r[win_buf];
          default: begin
            if (widx >= `W_DATA0 && widx < `W_DATA0 + 4'h8)
              rd_v = data_r[didx];
            else
              hit = 1'b0;
          end
        endcase
      end
    end else begin
      // unmapped words answer with an error and read zero
      case (PADDR)
        `A_MODULE_CONTROL: rd_v = ctl_r;
        `A_MODULE_STATE:   rd_v = {mode_r, 1'b0, icode, 1'b0};
        `A_LINK_ERR_STATE: rd_v = link_error_state;
        `A_TX_ERR_COUNTER: rd_v = tec_r;
        `A_RX_ERR_COUNTER: rd_v = rec_r;
        default:           hit  = 1'b0;
      endcase
    end
  end

  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      PRDATA       <= 32'h0;
      PREADY       <= 1'b0;
      PSLVERR      <= 1'b0;
      o_mode_state <= `MODE_CONFIG;
      o_bus_off    <= 1'b0;
    end else begin
      // ready pulses for the access cycle, registered from the setup cycle one clock earlier
      PREADY       <= PSEL & ~PENABLE;
      PSLVERR      <= PSEL & ~PENABLE & ~hit;
      // read data is caught at setup so it stands through the access cycle
      PRDATA       <= (PSEL & ~PENABLE & ~PWRITE) ? {24'h0, rd_v} : 32'h0;
      // mode and bus-off mirrors run one clock behind their registers
      o_mode_state <= mode_r;
      o_bus_off    <= busoff_r;
    end
  end
endmodule // can_ctrl_status_tx_buffers
`default_nettype wire

// ### can_ctrl_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "can_regs_defs.vh"
// ----------
// register port checks
// ----------
module can_ctrl_checker (
  input wire logic        I_CLK,
  input wire logic        I_RESET_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        i_mode_ack,
  input wire logic [2:0]  o_mode_state,
  input wire logic        o_tx_start,
  input wire logic        o_bus_off
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  wire logic rd_acc = PSEL && PENABLE && !PWRITE;
  wire logic st_rd  = rd_acc && PADDR == `A_MODULE_STATE;
  wire logic le_rd  = rd_acc && PADDR == `A_LINK_ERR_STATE;
  wire logic ct_rd  = rd_acc && PADDR == `A_MODULE_CONTROL;
  ready_slot_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready in access cycle");
  state_read_a: assert property (st_rd |-> PRDATA[7:4] == {o_mode_state, 1'h0})
    else $error("state read differs from mode");
  mode_legal_a: assert property (o_mode_state <= 3'h4)
    else $error("reserved mode code");
  mode_ack_a: assert property (!$stable(o_mode_state) |-> $past(i_mode_ack, 2))
    else $error("mode moved without ack");
  upper_zero_a: assert property (PREADY |-> PRDATA[31:8] == 24'h000000)
    else $error("upper read bits set");
  ctrl_bit0_a: assert property (ct_rd |-> !PRDATA[0] && !$past(PREADY))
    else $error("control bit 0 set");
  any_warn_a: assert property (le_rd |-> PRDATA[0] == (PRDATA[1] || PRDATA[2]))
    else $error("warning flag not an or");
  passive_warn_a: assert property (le_rd |-> (!PRDATA[4] || PRDATA[2]) && (!PRDATA[3] || PRDATA[1]))
    else $error("passive without warning");
  bus_off_flag_a: assert property (le_rd |-> PRDATA[5] == o_bus_off)
    else $error("bus-off flag differs");
  start_mode_a: assert property (o_tx_start |-> !o_bus_off && !o_mode_state[2] && !o_mode_state[0])
    else $error("launch in blocked state");
  refuse_zero_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h00000000)
    else $error("refused access returned data");
  cover property (o_tx_start);
  cover property (PSLVERR);
  cover property ($fell(o_bus_off));
endmodule // can_ctrl_checker
`default_nettype wire

// ### can_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------
// protocol engine stand-in
// ----------
module can_engine_model #(
  parameter int LAT = 12
) (
  input  wire logic I_CLK,
  input  wire logic I_RESET_N,
  input  wire logic o_tx_start,
  input  wire logic o_tx_abort,
  output var  logic i_mode_ack,
  output var  logic i_tx_done,
  output var  logic i_tx_abort_ack
);
  logic [7:0] left_r;
  // acks a mode change only every other cycle, like a busy engine
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      left_r         <= 8'h00;
      i_mode_ack     <= 1'h0;
      i_tx_done      <= 1'h0;
      i_tx_abort_ack <= 1'h0;
    end else begin
      i_mode_ack     <= ~i_mode_ack;
      i_tx_done      <= left_r == 8'h01;
      i_tx_abort_ack <= o_tx_abort && left_r != 8'h00;
      left_r         <= o_tx_start ? 8'(LAT) : o_tx_abort ? 8'h00 :
                        (left_r != 8'h00) ? left_r - 8'h01 : 8'h00;
    end
  end
endmodule // can_engine_model
`default_nettype wire

// ### tb_can_ctrl_status_tx_buffers.sv
`timescale 1ns/1ns
`default_nettype none
`include "can_regs_defs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module tb_can_ctrl_status_tx_buffers;
  logic        I_CLK = 1'h0, I_RESET_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h00000000, PRDATA;
  logic        PREADY, PSLVERR, i_mode_ack, i_tx_done, i_tx_abort_ack, er;
  logic        i_tx_lost_arb = 1'h0, i_tx_bus_err = 1'h0, i_tx_err_inc8 = 1'h0;
  logic        i_tx_err_dec = 1'h0, i_bit_tick = 1'h0, i_rx_bit = 1'h1;
  logic        i_rx0_ovf = 1'h0, i_rx1_ovf = 1'h0, o_tx_start, o_tx_abort, o_tx_ext, o_bus_off;
  logic [6:0]  i_irq_pend = 7'h00;
  logic [2:0]  o_mode_state;
  logic [1:0]  o_tx_sel;
  logic [28:0] o_tx_id;
  logic [7:0]  rd;
  logic [2:0]  rq[5] = '{3'h7, 3'h3, 3'h2, 3'h1, 3'h0};
  logic [2:0]  ex[5] = '{3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  int          checks = 0, fail_count = 0, n, i;
  can_ctrl_status_tx_buffers u_can_ctrl_status_tx_buffers (.*);
  can_engine_model #(.LAT(12)) u_can_engine_model (.*);
  always #50 I_CLK = ~I_CLK;
  // ----------
  // bus tasks
  // ----------
  task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h000000, d};
    @(posedge I_CLK);
    PENABLE <= 1'h1;
    n = 0;
    do begin @(posedge I_CLK); n++; end while (PREADY !== 1'h1 && n < 20);
    if (n >= 20) `CHK(1'h0, 1'h1)
    rd = PRDATA[7:0];
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  // polls so that self-clearing bits get time to settle
  task rdc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    int k;
    k = 0;
    do begin bus(1'h0, a, 8'h00); k++; end while ((rd & m) !== e && k < 30);
    `CHK(rd & m, e)
  endtask
  task wstart;
    n = 0;
    while (o_tx_start !== 1'h1 && n < 40) begin @(posedge I_CLK); n++; end
    if (n >= 40) `CHK(1'h0, 1'h1)
  endtask
  task tick;
    @(posedge I_CLK) i_bit_tick <= 1'h1;
    @(posedge I_CLK) i_bit_tick <= 1'h0;
  endtask
  task inc8;
    @(posedge I_CLK) i_tx_err_inc8 <= 1'h1;
    @(posedge I_CLK) i_tx_err_inc8 <= 1'h0;
  endtask
  function automatic logic [7:0] img(int k);
    return (k == 1) ? 8'hA5 : (k == 2) ? 8'hFF : (k == 3) ? 8'h3C : (k == 4) ? 8'h5A : 8'(8'h10 + k);
  endfunction
  task end_sim;
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------
  // tests
  // ----------
  initial begin
    repeat (4) @(posedge I_CLK);
    I_RESET_N <= 1'h1;
    rdc(`A_MODULE_CONTROL, 8'hFF, 8'h80);
    rdc(`A_MODULE_STATE, 8'hFF, 8'h80);
    bus(1'h0, `A_EVENT_IN, 8'h00);
    `CHK({er, rd}, 9'h100)
    for (i = 0; i < 5; i++) begin
      bus(1'h1, `A_MODULE_CONTROL, {rq[i], 5'h00});
      rdc(`A_MODULE_STATE, 8'hE0, {ex[i], 5'h00});
    end
    for (i = 0; i < 7; i++) begin
      i_irq_pend <= 7'h01 << i;
      rdc(`A_MODULE_STATE, 8'h0E, {4'h0, i[2:0] + 3'h1, 1'h0});
    end
    i_irq_pend <= 7'h7F;
    rdc(`A_MODULE_STATE, 8'h0E, 8'h0E);
    i_irq_pend <= 7'h08;
    rdc(`A_MODULE_STATE, 8'hFF, 8'h08);
    bus(1'h1, `A_MODULE_CONTROL, rd);
    for (i = 1; i < 13; i++) bus(1'h1, `A_WIN_BASE + {i[9:0], 2'h0}, img(i));
    for (i = 1; i < 13; i++) rdc(`A_WIN_BASE + {i[9:0], 2'h0}, 8'hFF, (i == 2) ? 8'hEB : img(i));
    bus(1'h1, `A_WIN_BASE, 8'h0B);
    wstart();
    `CHK({o_tx_sel, o_tx_ext, o_tx_id}, {2'h0, 1'h1, 8'hA5, 3'h7, 2'h3, 8'h3C, 8'h5A})
    rdc(`A_WIN_BASE, 8'hFF, 8'h03);
    bus(1'h1, `A_MODULE_CONTROL, 8'h66);
    rdc(`A_MODULE_STATE, 8'hE0, 8'h60);
    bus(1'h1, `A_WIN_BASE, 8'h09);
    bus(1'h1, `A_MODULE_CONTROL, 8'h64);
    bus(1'h1, `A_WIN_BASE, 8'h0B);
    bus(1'h1, `A_MODULE_CONTROL, 8'h00);
    rdc(`A_WIN_BASE, 8'hFF, 8'h00);
    wstart();
    `CHK(o_tx_sel, 2'h2)
    @(posedge I_CLK);
    wstart();
    `CHK(o_tx_sel, 2'h1)
    bus(1'h1, `A_MODULE_CONTROL, 8'h06);
    rdc(`A_WIN_BASE, 8'hFF, 8'h01);
    bus(1'h1, `A_MODULE_CONTROL, 8'h68);
    rdc(`A_MODULE_STATE, 8'hE0, 8'h60);
    bus(1'h1, `A_WIN_BASE, 8'h08);
    bus(1'h1, `A_WIN_BASE, 8'h00);
    rdc(`A_WIN_BASE, 8'hFF, 8'h40);
    bus(1'h1, `A_MODULE_CONTROL, 8'h66);
    bus(1'h1, `A_WIN_BASE, 8'h08);
    bus(1'h1, `A_MODULE_CONTROL, 8'h76);
    rdc(`A_MODULE_CONTROL, 8'hFF, 8'h66);
    rdc(`A_WIN_BASE, 8'hFF, 8'h40);
    bus(1'h1, `A_MODULE_CONTROL, 8'h08);
    bus(1'h1, `A_WIN_BASE, 8'h08);
    wstart();
    bus(1'h1, `A_WIN_BASE, 8'h00);
    @(posedge I_CLK);
    `CHK(o_tx_abort, 1'h1)
    rdc(`A_WIN_BASE, 8'hFF, 8'h40);
    bus(1'h1, `A_WIN_BASE, 8'h08);
    wstart();
    @(posedge I_CLK) i_tx_lost_arb <= 1'h1;
    @(posedge I_CLK) i_tx_lost_arb <= 1'h0;
    rdc(`A_WIN_BASE, 8'hFF, 8'h28);
    @(posedge I_CLK) i_tx_bus_err <= 1'h1;
    @(posedge I_CLK) i_tx_bus_err <= 1'h0;
    rdc(`A_WIN_BASE, 8'hFF, 8'h38);
    rdc(`A_WIN_BASE, 8'hFF, 8'h30);
    bus(1'h1, `A_TX_ERR_COUNTER, 8'h60);
    rdc(`A_LINK_ERR_STATE, 8'h3F, 8'h05);
    bus(1'h1, `A_TX_ERR_COUNTER, 8'h80);
    bus(1'h1, `A_RX_ERR_COUNTER, 8'h80);
    rdc(`A_LINK_ERR_STATE, 8'h3F, 8'h1F);
    bus(1'h1, `A_TX_ERR_COUNTER, 8'hF7);
    inc8();
    rdc(`A_TX_ERR_COUNTER, 8'hFF, 8'hFF);
    `CHK(o_bus_off, 1'h0)
    inc8();
    rdc(`A_LINK_ERR_STATE, 8'h20, 8'h20);
    repeat (5) tick();
    i_rx_bit <= 1'h0;
    tick();
    i_rx_bit <= 1'h1;
    repeat (10) tick();
    @(posedge I_CLK);
    `CHK(o_bus_off, 1'h1)
    tick();
    rdc(`A_TX_ERR_COUNTER, 8'hFF, 8'h00);
    `CHK(o_bus_off, 1'h0)
    bus(1'h1, `A_TX_ERR_COUNTER, 8'h10);
    @(posedge I_CLK) i_tx_err_dec <= 1'h1;
    @(posedge I_CLK) i_tx_err_dec <= 1'h0;
    rdc(`A_TX_ERR_COUNTER, 8'hFF, 8'h0F);
    @(posedge I_CLK) {i_rx0_ovf, i_rx1_ovf} <= 2'h3;
    @(posedge I_CLK) {i_rx0_ovf, i_rx1_ovf} <= 2'h0;
    rdc(`A_LINK_ERR_STATE, 8'hC0, 8'hC0);
    bus(1'h1, `A_LINK_ERR_STATE, 8'hBF);
    rdc(`A_LINK_ERR_STATE, 8'hC0, 8'h80);
    end_sim();
  end
  initial begin
    #2000000;
    fail_count++;
    end_sim();
  end
endmodule // tb_can_ctrl_status_tx_buffers
bind can_ctrl_status_tx_buffers can_ctrl_checker u_can_ctrl_checker (.*);
`default_nettype wire
